/* rtl/ubt_engine.sv */
`timescale 1ns/1ps
`default_nettype none
module ubt_engine
  import ubt_pkg::*;
#(
  parameter int BUF_DEPTH = 2
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [1:0] mode,
  input wire logic in_req,
  input wire logic out_req,
  input wire logic dev_stop,
  input wire logic [15:0] src_data,
  input wire logic src_valid,
  output logic src_ready,
  output logic [15:0] snk_data,
  output logic snk_valid,
  input wire logic snk_ready,
  input wire logic cmd_done,
  output logic crc_err,
  output logic [15:0] err_rx,
  output logic [15:0] err_calc,
  input wire ubt_pin_in_t pin_in,
  output ubt_pin_out_t pin_out
);
  localparam int SS_MIN = T_SS_CYC;
  localparam int AZ_MAX = T_AZ_CYC;
  localparam int LI_MAX = T_LI_CYC;
  localparam int LL_MAX = T_LL_CYC;
  localparam int IORDYZ_MAX = T_IORDYZ_CYC;

  ubt_state_t state_reg, state_next;
  ubt_pin_in_t s1_reg, s2_reg, p_reg;
  ubt_pin_out_t out_reg, out_next;
  logic [TMR_W-1:0] tmr_reg, tmr_next, age_reg;
  logic [15:0] crc_reg, crc_next, rx_reg;
  logic pend_reg, pend_next, err_reg, first_reg, first_next;
  logic [15:0] erx_reg, ecalc_reg;
  logic push, buf_ready, buf_valid, stb_edge;

  //==============================================================
  // Pin views after the two-flop synchroniser
  wire dmack = ~s2_reg.dmack_n;
  wire dmack_end = s2_reg.dmack_n & ~p_reg.dmack_n;
  wire stop = s2_reg.stop;
  wire hrdy = ~s2_reg.hstb;
  wire hstb_edge = s2_reg.hstb ^ p_reg.hstb;
  wire crc_bad = (s2_reg.dd != crc_reg);
  wire chk = dmack_end && (state_reg == ST_IN_END || state_reg == ST_OUT_END);
  wire [TMR_W-1:0] space = (mode == 2'd0) ? TMR_W'(SPACE_M0) :
                           (mode == 2'd1) ? TMR_W'(SPACE_M1) : TMR_W'(SPACE_M2);
  wire tmr_done = (tmr_reg == '0);
  // Pause out-ready only once a word waits and the sink is stalled
  wire out_hold = first_reg & buf_valid & ~snk_ready;

  assign pin_out = out_reg;
  assign snk_valid = buf_valid;
  assign crc_err = err_reg;
  assign err_rx = erx_reg;
  assign err_calc = ecalc_reg;

  //==============================================================
  // Next state of the burst engine
  always_comb begin
    state_next = state_reg;
    out_next = out_reg;
    tmr_next = tmr_done ? '0 : tmr_reg - TMR_W'(1);
    crc_next = crc_reg;
    first_next = first_reg;
    src_ready = 1'b0;
    push = 1'b0;
    stb_edge = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (in_req && src_valid) begin
          out_next.dmarq = 1'b1;
          state_next = ST_IN_ACK;
        end else if (out_req) begin
          out_next.dmarq = 1'b1;
          tmr_next = TMR_W'(T_ZORDY_CYC);
          state_next = ST_OUT_ACK;
        end
      end
      ST_IN_ACK: begin
        if (dmack) begin
          crc_next = CRC_SEED;
          out_next.stb = 1'b1;
          out_next.stb_oe = 1'b1;
          out_next.dd = src_data;
          if (!stop && hrdy && out_reg.stb_oe) begin
            out_next.dd_oe = 1'b1;
            tmr_next = space;
            state_next = ST_IN_XFER;
          end
        end
      end
      ST_IN_XFER: begin
        out_next.dd = src_data;
        if (stop) begin
          out_next.dmarq = 1'b0;
          out_next.dd_oe = 1'b0;
          out_next.stb = 1'b1;
          state_next = ST_IN_END;
        end else if (dev_stop || !src_valid) begin
          tmr_next = TMR_W'(T_SS_CYC);
          state_next = ST_IN_SS;
        end else if (tmr_done && hrdy) begin
          // Edges wait for host ready, so a pause stops them
          out_next.stb = ~out_reg.stb;
          crc_next = crc_step(crc_reg, out_reg.dd);
          src_ready = 1'b1;
          stb_edge = 1'b1;
          tmr_next = space;
        end
      end
      ST_IN_SS: begin
        if (stop || tmr_done) begin
          out_next.dmarq = 1'b0;
          out_next.dd_oe = 1'b0;
          state_next = ST_IN_END;
        end
      end
      ST_IN_END: begin
        // Acknowledge end is awaited here; a host stop parks the strobe high
        if (stop && !out_reg.stb) begin
          out_next.stb = 1'b1;
        end
        if (dmack_end) begin
          out_next.stb_oe = 1'b0;
          state_next = ST_IDLE;
        end
      end
      ST_OUT_ACK: begin
        if (!dmack) begin
          tmr_next = TMR_W'(T_ZORDY_CYC);
        end else begin
          crc_next = CRC_SEED;
          first_next = 1'b0;
          if (tmr_done && !out_reg.stb_oe) begin
            out_next.stb = 1'b1;
            out_next.stb_oe = 1'b1;
          end else if (out_reg.stb_oe && !stop) begin
            out_next.stb = 1'b0;
            state_next = ST_OUT_XFER;
          end
        end
      end
      ST_OUT_XFER: begin
        if (stop) begin
          out_next.dmarq = 1'b0;
          out_next.stb = 1'b1;
          state_next = ST_OUT_END;
        end else begin
          if (hstb_edge) begin
            push = 1'b1;
            first_next = 1'b1;
            crc_next = crc_step(crc_reg, s2_reg.dd);
          end
          out_next.stb = out_hold;
        end
      end
      ST_OUT_END: begin
        if (dmack_end) begin
          out_next.stb_oe = 1'b0;
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
        out_next = '0;
      end
    endcase
  end

  // First miscompare of a command wins; a new one set in the same
  // cycle as command completion still counts
  always_comb begin
    pend_next = pend_reg;
    if (cmd_done) pend_next = 1'b0;
    if (chk && crc_bad && !pend_reg) pend_next = 1'b1;
  end

  //==============================================================
  // Synchroniser and edge history
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s1_reg <= '{dmack_n: 1'b1, stop: 1'b0, hstb: 1'b1, dd: '0};
      s2_reg <= '{dmack_n: 1'b1, stop: 1'b0, hstb: 1'b1, dd: '0};
      p_reg <= '{dmack_n: 1'b1, stop: 1'b0, hstb: 1'b1, dd: '0};
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      p_reg <= s2_reg;
    end
  end

  // Engine state
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
      out_reg <= '0;
      tmr_reg <= '0;
      crc_reg <= CRC_SEED;
      first_reg <= 1'b0;
      age_reg <= '0;
    end else begin
      state_reg <= state_next;
      out_reg <= out_next;
      tmr_reg <= tmr_next;
      crc_reg <= crc_next;
      first_reg <= first_next;
      age_reg <= stb_edge ? '0 : (&age_reg ? age_reg : age_reg + TMR_W'(1));
    end
  end

  // CRC check at acknowledge end and error report
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rx_reg <= '0;
      pend_reg <= 1'b0;
      err_reg <= 1'b0;
      erx_reg <= '0;
      ecalc_reg <= '0;
    end else begin
      if (chk) rx_reg <= s2_reg.dd;
      if (chk && crc_bad && !pend_reg) begin
        erx_reg <= s2_reg.dd;
        ecalc_reg <= crc_reg;
      end
      pend_reg <= pend_next;
      if (cmd_done) err_reg <= pend_reg || (chk && crc_bad);
    end
  end

  //==============================================================
  // Received data-out words; a waiting word with the sink stalled pauses the host
  ubt_fifo #(.W(16), .D(BUF_DEPTH)) u_buf (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .in_data(s2_reg.dd),
    .in_valid(push),
    .in_ready(buf_ready),
    .out_data(snk_data),
    .out_valid(buf_valid),
    .out_ready(snk_ready)
  );

  //==============================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  dmarq_late_a: assert property ($fell(out_reg.dmarq) && $past(state_reg) == ST_IN_SS &&
    !$past(stop) |-> age_reg >= TMR_W'(SS_MIN)) else $error("request dropped too early");
  dd_release_a: assert property ($fell(out_reg.dmarq) && $past(state_reg) != ST_OUT_XFER
    |-> ##[0:AZ_MAX] !out_reg.dd_oe) else $error("data bus not released");
  stb_park_a: assert property (state_reg == ST_IN_END && stop && !out_reg.stb
    |-> ##[1:LI_MAX] out_reg.stb) else $error("strobe not parked high");
  crc_latch_a: assert property (chk |=> rx_reg == $past(s2_reg.dd))
    else $error("host CRC not captured");
  first_err_a: assert property (pend_reg && !cmd_done |=> pend_reg && $stable(erx_reg))
    else $error("first CRC error overwritten");
  stb_free_a: assert property (chk && state_reg == ST_IN_END
    |-> ##[1:IORDYZ_MAX] !out_reg.stb_oe) else $error("strobe not released");
  // A stop during the pause parks the strobe high; that edge carries no word
  no_edge_a: assert property (state_reg == ST_IN_XFER && !hrdy
    |=> $stable(out_reg.stb) || (state_reg == ST_IN_END && out_reg.stb))
    else $error("strobe edge while host not ready");
  edge_gap_a: assert property (stb_edge && $past(state_reg) == ST_IN_XFER
    |-> age_reg >= space) else $error("strobe edges too close");
  dmarq_stop_a: assert property (state_reg == ST_IN_XFER && stop
    |-> ##[1:LL_MAX] !out_reg.dmarq) else $error("request not dropped on stop");
  rdy_assert_a: assert property (state_reg == ST_OUT_ACK && out_reg.stb_oe && dmack
    && !stop |-> ##[1:LL_MAX] !out_reg.stb) else $error("out-ready not asserted");
  rdy_drive_a: assert property (out_reg.stb_oe &&
    state_reg inside {ST_OUT_XFER, ST_OUT_END}
    |=> out_reg.stb_oe || $past(dmack_end)) else $error("out-ready released early");
  crc_seed_a: assert property ($rose(dmack) && state_reg == ST_IN_ACK
    |=> crc_reg == CRC_SEED) else $error("CRC not seeded");
  // Seven cycles cover the pause reaction limit at this clock
  rfs_a: assert property (state_reg == ST_IN_XFER && $fell(hrdy)
    |-> (!stb_edge || hrdy) [*7]) else $error("edges continue after pause");

  host_end_c: cover property (state_reg == ST_IN_XFER && stop);
  dev_end_c: cover property (state_reg == ST_IN_SS ##1 state_reg == ST_IN_END);
  out_word_c: cover property (push && buf_ready);
  crc_err_c: cover property (chk && crc_bad);
endmodule
`default_nettype wire

/* rtl/ubt_pkg.sv */
//==============================================================
// Operation
// - Device ends data-in: stop edges, drop request late
// - Release data bus soon after request drops
// - Park strobe high once stop seen
// - Capture host CRC at acknowledge end
// - Compare CRC, report first miscompare per command
// - Release strobe soon after acknowledge ends
// - Stop strobe edges when host not ready
// - Drop request quickly after host stop
// - Drive out-ready negated after acknowledge, hold
// - Assert out-ready after stop drops, hold
// - Running CRC seeded each burst, per word
// - Burst spans acknowledge assert to negate
package ubt_pkg;

  //==============================================================
  // Timing
  localparam int CLK_MHZ = 100;
  localparam int T_SS_NS = 50;
  localparam int T_AZ_NS = 10;
  localparam int T_LI_NS = 150;
  localparam int T_LL_NS = 150;
  localparam int T_RFS_NS = 75;
  localparam int T_IORDYZ_NS = 20;
  localparam int T_ZORDY_NS = 20;
  localparam int T_CYC_M0_NS = 120;
  localparam int T_CYC_M1_NS = 80;
  localparam int T_CYC_M2_NS = 60;
  localparam int T_DVS_M0_NS = 70;
  localparam int T_DVS_M1_NS = 50;
  localparam int T_DVS_M2_NS = 35;

  // Least times round up, longest times round down, never below one
  function automatic int cyc_min(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int cyc_max(input int ns);
    int c;
    c = (ns * CLK_MHZ) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  // Data change lags the edge by one cycle, hence the extra cycle
  function automatic int space_of(input int cyc_ns, input int dvs_ns);
    int a;
    int b;
    a = cyc_min(cyc_ns);
    b = cyc_min(dvs_ns) + 1;
    return (a > b) ? a : b;
  endfunction

  localparam int T_SS_CYC = cyc_min(T_SS_NS);
  localparam int T_ZORDY_CYC = cyc_min(T_ZORDY_NS);
  localparam int T_AZ_CYC = cyc_max(T_AZ_NS);
  localparam int T_LI_CYC = cyc_max(T_LI_NS);
  localparam int T_LL_CYC = cyc_max(T_LL_NS);
  localparam int T_RFS_CYC = cyc_max(T_RFS_NS);
  localparam int T_IORDYZ_CYC = cyc_max(T_IORDYZ_NS);
  localparam int SPACE_M0 = space_of(T_CYC_M0_NS, T_DVS_M0_NS);
  localparam int SPACE_M1 = space_of(T_CYC_M1_NS, T_DVS_M1_NS);
  localparam int SPACE_M2 = space_of(T_CYC_M2_NS, T_DVS_M2_NS);
  localparam int TMR_W = 8;

  //==============================================================
  // CRC
  localparam logic [15:0] CRC_SEED = 16'h4ABA;
  localparam logic [15:0] CRC_POLY = 16'h1021;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [15:0] d);
    logic [15:0] r;
    logic fb;
    r = c;
    for (int i = 15; i >= 0; i--) begin
      fb = r[15] ^ d[i];
      r = {r[14:0], 1'b0};
      if (fb) begin
        r = r ^ CRC_POLY;
      end
    end
    return r;
  endfunction

  //==============================================================
  // Types
  typedef enum logic [2:0] {
    ST_IDLE, ST_IN_ACK, ST_IN_XFER, ST_IN_SS, ST_IN_END, ST_OUT_ACK, ST_OUT_XFER, ST_OUT_END
  } ubt_state_t;

  typedef struct packed {
    logic dmack_n;
    logic stop;
    logic hstb;
    logic [15:0] dd;
  } ubt_pin_in_t;

  typedef struct packed {
    logic dmarq;
    logic stb;
    logic stb_oe;
    logic [15:0] dd;
    logic dd_oe;
  } ubt_pin_out_t;

endpackage

/* rtl/ubt_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module ubt_fifo
  import ubt_pkg::*;
#(
  parameter int W = 16,
  parameter int D = 2
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);

  logic [W-1:0] mem_reg [D];
  logic [AW-1:0] wp_reg, rp_reg;
  logic [CW-1:0] cnt_reg;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  wire [AW-1:0] wp_next = (wp_reg == AW'(D - 1)) ? '0 : wp_reg + AW'(1);
  wire [AW-1:0] rp_next = (rp_reg == AW'(D - 1)) ? '0 : rp_reg + AW'(1);

  //==============================================================
  // Flags; full blocks the writer, so no word is overwritten
  assign in_ready = (cnt_reg != CW'(D));
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem_reg[rp_reg];

  // One storage word per entry
  for (genvar i = 0; i < D; i++) begin : g_ent
    always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
        mem_reg[i] <= '0;
      end else if (push && wp_reg == AW'(i)) begin
        mem_reg[i] <= in_data;
      end
    end
  end

  // Pointers and fill level
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) wp_reg <= wp_next;
      if (pop) rp_reg <= rp_next;
      if (push != pop) cnt_reg <= push ? cnt_reg + CW'(1) : cnt_reg - CW'(1);
    end
  end
endmodule
`default_nettype wire

/* test/ubt_host.sv */
`timescale 1ns/1ps
`default_nettype none
module ubt_host
  import ubt_pkg::*;
(
  input wire logic sys_clk,
  input wire logic hclk,
  input wire ubt_pin_out_t pin_out,
  output var ubt_pin_in_t pin_in
);
  //==============================================================
  // Host state and measurements
  logic ack_n_reg = 1'b1;
  logic stop_reg = 1'b0;
  logic hstb_reg = 1'b1;
  logic dd_oe_reg = 1'b0;
  logic [15:0] dd_reg = 16'h0000;
  logic prev_stb = 1'b0;
  logic prev_rq = 1'b0;
  logic [15:0] crc_run = 16'h4ABA;
  logic [15:0] rx_q[$];
  logic dd_at_fall;
  logic oe_after;
  logic rdy_seen;
  logic rq_first;
  logic [1:0] end_stb;
  logic [1:0] ack_seen;
  int to_cnt = 0;
  time t_edge = 0;
  time t_gap = 0;
  time t_fall = 0;
  time t_pause = 0;
  time t_stop = 0;

  // Released bus shows the inverse of the host's last word, never a held value
  assign pin_in = {ack_n_reg, stop_reg, hstb_reg,
                   dd_oe_reg ? dd_reg : (pin_out.dd_oe ? pin_out.dd : ~dd_reg)};

  function automatic logic [15:0] hcrc(input logic [15:0] c, input logic [15:0] d);
    for (int i = 15; i >= 0; i--) begin
      c = (c[15] ^ d[i]) ? ({c[14:0], 1'b0} ^ 16'h1021) : {c[14:0], 1'b0};
    end
    return c;
  endfunction

  // Data edge: strobe moved while the device drives the bus; extra words accepted
  always @(posedge sys_clk) begin
    prev_stb <= pin_out.stb;
    prev_rq <= pin_out.dmarq;
    if (pin_out.stb_oe && pin_out.dd_oe && pin_out.stb != prev_stb) begin
      rx_q.push_back(pin_out.dd);
      crc_run <= hcrc(crc_run, pin_out.dd);
      if (t_edge != 0 && $time - t_edge < t_gap) t_gap <= $time - t_edge;
      t_edge <= $time;
    end
    if (prev_rq && !pin_out.dmarq) begin
      t_fall <= $time;
      dd_at_fall <= pin_out.dd_oe;
    end
  end

  //==============================================================
  // Bounded waits: 0 request level, 1 strobe level, 2 received count
  task automatic wait_for(input int sel, input int v);
    int n;
    n = 0;
    while (n < 400 && (sel == 0 ? pin_out.dmarq != v :
                       sel == 1 ? pin_out.stb != v : rx_q.size() < v)) begin
      @(posedge hclk);
      n++;
    end
    if (n == 400) to_cnt++;
  endtask

  task automatic open_burst();
    crc_run <= 16'h4ABA;
    rx_q.delete();
    t_edge <= 0;
    t_gap <= 1000000;
    wait_for(0, 1);
    stop_reg <= 1'b1;
    hstb_reg <= 1'b1;
    @(posedge hclk);
    ack_n_reg <= 1'b0;
    @(posedge hclk);
  endtask

  task automatic close_burst(input logic [15:0] flip);
    stop_reg <= 1'b1;
    hstb_reg <= 1'b1;
    t_stop <= $time;
    wait_for(0, 0);
    @(posedge hclk);
    dd_reg <= crc_run ^ flip;
    dd_oe_reg <= 1'b1;
    repeat (2) @(posedge hclk);
    end_stb <= {pin_out.stb_oe, pin_out.stb};
    ack_n_reg <= 1'b1;
    repeat (2) @(posedge hclk);
    oe_after <= pin_out.stb_oe;
    stop_reg <= 1'b0;
    dd_oe_reg <= 1'b0;
  endtask

  // k zero waits for the device to end the burst
  task automatic burst_in(input int k, input logic [15:0] flip);
    open_burst();
    stop_reg <= 1'b0;
    hstb_reg <= 1'b0;
    if (k > 0) begin
      wait_for(2, k);
      hstb_reg <= 1'b1;
      t_pause <= $time;
      repeat (2) @(posedge hclk);
    end else begin
      wait_for(0, 0);
    end
    close_burst(flip);
  endtask

  // Two link cycles per word keep setup, hold and spacing for every mode
  task automatic burst_out(input int n, input logic [15:0] flip);
    open_burst();
    ack_seen <= {pin_out.stb_oe, pin_out.stb};
    stop_reg <= 1'b0;
    @(posedge hclk);
    rdy_seen <= pin_out.stb;
    rq_first <= pin_out.dmarq;
    @(posedge hclk);
    for (int i = 0; i < n; i++) begin
      dd_reg <= 16'h5000 + 16'(i);
      dd_oe_reg <= 1'b1;
      @(posedge hclk);
      wait_for(1, 0);
      hstb_reg <= ~hstb_reg;
      crc_run <= hcrc(crc_run, dd_reg);
      @(posedge hclk);
    end
    close_burst(flip);
  endtask
endmodule
`default_nettype wire

/* test/ubt_engine_test.sv */
`timescale 1ns/1ps
`default_nettype none
module ubt_engine_test;
  import ubt_pkg::*;
  logic sys_clk = 1'b0;
  logic hclk = 1'b0;
  logic nrst = 1'b0;
  logic [1:0] mode = 2'h0;
  logic in_req = 1'b0;
  logic out_req = 1'b0;
  logic dev_stop = 1'b0;
  logic [15:0] src_data = 16'hA000;
  logic src_valid = 1'b0;
  logic snk_ready = 1'b1;
  logic cmd_done = 1'b0;
  logic src_ready;
  logic [15:0] snk_data;
  logic snk_valid;
  logic crc_err;
  logic [15:0] err_rx;
  logic [15:0] err_calc;
  ubt_pin_in_t pin_in;
  ubt_pin_out_t pin_out;
  int src_left = 0;
  int err_count = 0;
  int n_checks = 0;
  logic [15:0] snk_q[$];

  //==============================================================
  // Clocks: host timing clock runs at an eighth of the core clock rate, at a fixed phase offset from it
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    #13;
    forever #40 hclk = ~hclk;
  end

  ubt_engine ubt_engine_inst (.sys_clk(sys_clk), .nrst(nrst), .mode(mode), .in_req(in_req),
    .out_req(out_req), .dev_stop(dev_stop), .src_data(src_data), .src_valid(src_valid),
    .src_ready(src_ready), .snk_data(snk_data), .snk_valid(snk_valid), .snk_ready(snk_ready),
    .cmd_done(cmd_done), .crc_err(crc_err), .err_rx(err_rx), .err_calc(err_calc),
    .pin_in(pin_in), .pin_out(pin_out));
  ubt_host ubt_host_inst (.sys_clk(sys_clk), .hclk(hclk), .pin_out(pin_out), .pin_in(pin_in));

  // Source steps per consumed word, sink collects; requests drop once seen
  always @(posedge sys_clk) begin
    if (src_ready) begin
      src_data <= src_data + 16'h0001;
      src_left <= src_left - 1;
      src_valid <= (src_left > 1);
    end
    if (snk_valid && snk_ready) snk_q.push_back(snk_data);
    if (pin_out.dmarq) begin
      in_req <= 1'b0;
      out_req <= 1'b0;
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk_report(input logic bad, input logic [15:0] rx, input logic [15:0] calc);
    @(posedge sys_clk);
    cmd_done <= 1'b1;
    @(posedge sys_clk);
    cmd_done <= 1'b0;
    #1;
    chk(16'(crc_err), 16'(bad), "crc error flag");
    if (bad) begin
      chk(err_rx, rx, "host crc");
      chk(err_calc, calc, "device crc");
    end
  endtask

  //==============================================================
  // Device ends data-in by source running dry or by its own stop
  task automatic sc_dev_in(input logic [1:0] m, input int n, input logic use_stop,
                           input logic [15:0] flip);
    int tcyc;
    tcyc = (m == 0) ? T_CYC_M0_NS : (m == 1) ? T_CYC_M1_NS : T_CYC_M2_NS;
    @(posedge sys_clk);
    mode <= m;
    src_data <= 16'hA000;
    src_left <= use_stop ? 40 : n;
    // Old words would trip the stop branch before the burst opens
    ubt_host_inst.rx_q.delete();
    src_valid <= 1'b1;
    in_req <= 1'b1;
    fork
      ubt_host_inst.burst_in(0, flip);
      if (use_stop) begin
        for (int i = 0; i < 2000 && ubt_host_inst.rx_q.size() < n; i++) @(posedge sys_clk);
        dev_stop <= 1'b1;
      end
    join
    dev_stop <= 1'b0;
    src_valid <= 1'b0;
    if (!use_stop) chk(16'(ubt_host_inst.rx_q.size()), 16'(n), "word count");
    else chk(16'(ubt_host_inst.rx_q.size() >= n), 16'h0001, "words before stop");
    foreach (ubt_host_inst.rx_q[i])
      chk(ubt_host_inst.rx_q[i], 16'hA000 + 16'(i), "data-in word");
    chk(16'(ubt_host_inst.t_fall >= ubt_host_inst.t_edge + T_SS_NS), 16'h0001, "ss gap");
    chk(16'(ubt_host_inst.dd_at_fall), 16'h0000, "bus released");
    chk(16'(ubt_host_inst.end_stb), 16'h0003, "strobe parked high");
    chk(16'(ubt_host_inst.oe_after), 16'h0000, "strobe released");
    chk(16'(ubt_host_inst.t_gap >= tcyc), 16'h0001, "strobe spacing");
  endtask

  // Host pauses after four words, then stops the burst
  task automatic sc_host_in(input logic [15:0] flip);
    @(posedge sys_clk);
    mode <= 2'h2;
    src_data <= 16'hA000;
    src_left <= 40;
    src_valid <= 1'b1;
    in_req <= 1'b1;
    ubt_host_inst.burst_in(4, flip);
    src_valid <= 1'b0;
    foreach (ubt_host_inst.rx_q[i])
      chk(ubt_host_inst.rx_q[i], 16'hA000 + 16'(i), "data-in word");
    chk(16'(ubt_host_inst.t_edge <= ubt_host_inst.t_pause + T_RFS_NS + 10), 16'h0001,
        "edges stop");
    chk(16'(ubt_host_inst.t_fall <= ubt_host_inst.t_stop + T_LL_NS + 10), 16'h0001,
        "request drop");
    chk(16'(ubt_host_inst.end_stb), 16'h0003, "strobe parked high");
    chk_report(flip != 0, ubt_host_inst.crc_run ^ flip, ubt_host_inst.crc_run);
  endtask

  // Data-out with the sink stalled long enough to pause the host
  task automatic sc_out(input logic [15:0] flip);
    @(posedge sys_clk);
    snk_q.delete();
    snk_ready <= 1'b0;
    out_req <= 1'b1;
    fork
      ubt_host_inst.burst_out(6, flip);
      begin
        repeat (150) @(posedge sys_clk);
        snk_ready <= 1'b1;
      end
    join
    repeat (4) @(posedge sys_clk);
    chk(16'(snk_q.size()), 16'h0006, "words delivered");
    foreach (snk_q[i])
      chk(snk_q[i], 16'h5000 + 16'(i), "data-out word");
    chk(16'(ubt_host_inst.ack_seen), 16'h0003, "ready negated");
    chk(16'(ubt_host_inst.rdy_seen), 16'h0000, "ready asserted");
    chk(16'(ubt_host_inst.rq_first), 16'h0001, "request held");
    chk_report(flip != 0, ubt_host_inst.crc_run ^ flip, ubt_host_inst.crc_run);
  endtask

  // Two bad bursts in one command: only the first is reported
  task automatic sc_first_err();
    logic [15:0] c1;
    sc_dev_in(2'h1, 3, 1'b0, 16'h0001);
    c1 = ubt_host_inst.crc_run;
    sc_dev_in(2'h3, 3, 1'b1, 16'h0002);
    chk_report(1'b1, c1 ^ 16'h0001, c1);
    chk_report(1'b0, 16'h0000, 16'h0000);
  endtask

  initial begin
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    for (int m = 0; m < 3; m++) begin
      sc_dev_in(2'(m), 5, 1'b0, 16'h0000);
      chk_report(1'b0, 16'h0000, 16'h0000);
    end
    sc_host_in(16'h0040);
    sc_out(16'h0100);
    sc_first_err();
    chk(16'(ubt_host_inst.to_cnt), 16'h0000, "host waits in bound");
    give_verdict();
  end
endmodule
`default_nettype wire
